// [verilog/hrcs_pkg.sv]
// hrcs_pkg: constants, types and timing counts for the hub reset and config sequencer
package hrcs_pkg;

    // ==========================================================
    // clock and timing
    localparam int CLK_HZ = 10000000;
    localparam int CLK_PERIOD_NS = 100;
    localparam int NUM_PORTS = 4;

    // times in their own units, counts derived from the clock period
    localparam int T_RESET_MIN_NS = 1000;
    localparam int T_OPERATIONAL_US = 500;
    localparam int T_OUTPUTS_INACTIVE_NS = 2000;
    localparam int T_ATTACH_MS = 100;
    localparam int T_EEPROM_READ_US = 99500;
    localparam int T_REQUEST_MS = 5;

    // least times round up, longest times round down
    localparam int RESET_MIN_CYC = (T_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OPERATIONAL_CYC = (T_OPERATIONAL_US * 1000) / CLK_PERIOD_NS;
    localparam int OUTPUTS_INACTIVE_CYC = T_OUTPUTS_INACTIVE_NS / CLK_PERIOD_NS;
    localparam int ATTACH_CYC = (T_ATTACH_MS * 1000000) / CLK_PERIOD_NS;
    localparam int EEPROM_READ_CYC = (T_EEPROM_READ_US * 1000) / CLK_PERIOD_NS;
    localparam int REQUEST_CYC = (T_REQUEST_MS * 1000000) / CLK_PERIOD_NS;

    localparam int TIMER_W = 24;

    // ==========================================================
    // strap encodings
    localparam logic [1:0] CFG_DEFAULT = 2'h0;
    localparam logic [1:0] CFG_EEPROM = 2'h1;
    localparam logic [1:0] CFG_SMBUS = 2'h2;
    localparam logic [1:0] CFG_DEFAULT_ALT = 2'h3;

    localparam logic [6:0] USB_ADDR_RESET = 7'h00;

    // ==========================================================
    // sequencer states, one-hot
    typedef enum logic [7:0] {
        ST_IN_RESET = 8'h01,
        ST_RECOVER = 8'h02,
        ST_STRAP = 8'h04,
        ST_EEPROM = 8'h08,
        ST_SMBUS_WAIT = 8'h10,
        ST_APPLY = 8'h20,
        ST_ATTACHED = 8'h40,
        ST_FAULT = 8'h80
    } hrcs_state_type;

    // upstream usb state carried together
    typedef struct packed {
        logic [6:0] address;
        logic configured;
        logic suspended;
    } hrcs_usb_type;

endpackage

// [verilog/hrcs_timer.sv]
// hrcs_timer: loadable down counter with a one-cycle expiry pulse
`timescale 1ns/1ps
module hrcs_timer (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // control
    input wire logic load,
    input wire logic [hrcs_pkg::TIMER_W-1:0] load_value,
    input wire logic stop,
    // status
    output logic running,
    output logic expired
);
    logic [hrcs_pkg::TIMER_W-1:0] count_reg, count_next;
    logic running_reg, running_next;
    logic expired_reg, expired_next;

    // ==========================================================
    // next value: load wins over stop so a restart is never lost
    always_comb begin
        count_next = count_reg;
        running_next = running_reg;
        expired_next = 1'b0;
        if (load) begin
            count_next = load_value;
            running_next = 1'b1;
        end else if (stop) begin
            running_next = 1'b0;
        end else if (running_reg) begin
            if (count_reg <= 24'h000001) begin
                running_next = 1'b0;
                expired_next = 1'b1;
            end else begin
                count_next = count_reg - 24'h000001;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            count_reg <= 24'h000000;
            running_reg <= 1'b0;
            expired_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            running_reg <= running_next;
            expired_reg <= expired_next;
        end
    end

    assign running = running_reg;
    assign expired = expired_reg;
endmodule

// [verilog/hrcs_sequencer.sv]
// hrcs_sequencer: hub start-up flow after hardware reset and upstream bus reset handling
// Function
// RQ1: reset source holds hardware reset low at least 1 us.
// RQ2: become operational within 500 us of reset release, then start flow.
// RQ3: capture the two-bit strap at reset release and select the start-up flow.
// RQ4: in strap mode drive outputs inactive within 2 us of release.
// RQ5: in strap mode signal upstream attach within 100 ms of release.
// RQ6: host waits at least 100 ms after attach before bus reset.
// RQ7: finish each upstream control request within 5 ms.
// RQ8: in eeprom mode finish the configuration read within 99.5 ms.
// RQ9: bus-powered smbus host finishes the code load within 99.5 ms.
// RQ10: self-powered smbus mode waits without limit for the code load.
// RQ11: after smbus load apply settings and attach within 100 ms.
// RQ12: upstream bus reset sets address zero and unconfigured state.
// RQ13: bus reset drops port power except on battery-charge enabled ports.
// RQ14: bus reset flushes every transaction translator buffer.
// RQ15: bus reset while suspended returns the hub to active.
// RQ16: upstream bus reset is never passed downstream.
`timescale 1ns/1ps
module hrcs_sequencer (
    // clock and active-high synchronous reset (hardware reset pin, inverted upstream)
    input wire logic clk_sys,
    input wire logic reset,
    // configuration straps and power mode
    input wire logic [1:0] cfg_sel,
    input wire logic self_powered,
    // configuration loaders
    input wire logic eeprom_done,
    input wire logic smbus_load_done,
    // upstream usb events
    input wire logic usb_bus_reset,
    input wire logic usb_suspend,
    input wire logic usb_set_address,
    input wire logic [6:0] usb_new_address,
    input wire logic usb_set_config,
    input wire logic ctrl_request_start,
    input wire logic ctrl_request_done,
    // downstream port control
    input wire logic [hrcs_pkg::NUM_PORTS-1:0] battery_charge_port_en,
    input wire logic [hrcs_pkg::NUM_PORTS-1:0] port_power_request,
    // outputs
    output logic hub_operational,
    output logic outputs_active,
    output logic eeprom_read_en,
    output logic smbus_slave_en,
    output logic usb_attach,
    output logic [6:0] usb_address,
    output logic usb_configured,
    output logic usb_suspended,
    output logic [hrcs_pkg::NUM_PORTS-1:0] downstream_port_power_en,
    output logic tt_flush,
    output logic downstream_reset,
    output logic config_timeout,
    output logic request_timeout
);
    hrcs_pkg::hrcs_state_type state_reg, state_next;
    logic [1:0] strap_reg, strap_next;
    logic strap_taken_reg, strap_taken_next;
    hrcs_pkg::hrcs_usb_type usb_reg, usb_next;
    logic [hrcs_pkg::NUM_PORTS-1:0] pwr_reg, pwr_next;
    logic attach_reg, attach_next;
    logic active_reg, active_next;
    logic oper_reg, oper_next;
    logic flush_reg, flush_next;
    logic cfg_to_reg, cfg_to_next;
    logic req_to_reg, req_to_next;
    logic rd_en_reg, rd_en_next, slave_en_reg, slave_en_next;
    logic [4:0] inact_cnt_reg, inact_cnt_next;
    logic req_busy_reg, req_busy_next;
    logic [hrcs_pkg::TIMER_W-1:0] req_cnt_reg, req_cnt_next;
    logic tmr_load, tmr_stop, tmr_running, tmr_expired;
    logic [hrcs_pkg::TIMER_W-1:0] tmr_value;

    // a strap of 11 is treated as default, the safe choice for an unused code
    function automatic logic is_default_strap(input logic [1:0] s);
        return (s == hrcs_pkg::CFG_DEFAULT) || (s == hrcs_pkg::CFG_DEFAULT_ALT);
    endfunction

    function automatic logic [hrcs_pkg::TIMER_W-1:0] cyc(input int n);
        return hrcs_pkg::TIMER_W'(n);
    endfunction

    // ==========================================================
    // shared phase timer: recovery, config read limit and attach deadline
    hrcs_timer u_timer (
        .clk_sys(clk_sys),
        .reset(reset),
        .load(tmr_load),
        .load_value(tmr_value),
        .stop(tmr_stop),
        .running(tmr_running),
        .expired(tmr_expired)
    );

    // ==========================================================
    // start-up sequencer
    always_comb begin
        state_next = state_reg;
        strap_next = strap_reg;
        strap_taken_next = strap_taken_reg;
        oper_next = oper_reg;
        attach_next = attach_reg;
        cfg_to_next = cfg_to_reg;
        tmr_load = 1'b0;
        tmr_stop = 1'b0;
        tmr_value = cyc(hrcs_pkg::OPERATIONAL_CYC - 2); // load and flag edges fill the 500 us
        unique case (state_reg)
            hrcs_pkg::ST_IN_RESET: begin
                // first cycle after release: catch the strap, start recovery
                strap_next = cfg_sel; // RQ3
                strap_taken_next = 1'b1;
                tmr_load = 1'b1; // RQ2
                state_next = hrcs_pkg::ST_RECOVER;
            end
            hrcs_pkg::ST_RECOVER: begin
                if (tmr_expired) begin
                    oper_next = 1'b1; // RQ2
                    tmr_load = 1'b1;
                    if (is_default_strap(strap_reg)) begin // RQ3
                        // attach deadline counts from release; recovery already used some
                        tmr_value = cyc(hrcs_pkg::ATTACH_CYC - hrcs_pkg::OPERATIONAL_CYC); // RQ5
                        state_next = hrcs_pkg::ST_STRAP;
                    end else if (strap_reg == hrcs_pkg::CFG_EEPROM) begin
                        tmr_value = cyc(hrcs_pkg::EEPROM_READ_CYC); // RQ8
                        state_next = hrcs_pkg::ST_EEPROM;
                    end else begin
                        tmr_stop = self_powered; // RQ10
                        tmr_load = !self_powered; // RQ9
                        tmr_value = cyc(hrcs_pkg::EEPROM_READ_CYC);
                        state_next = hrcs_pkg::ST_SMBUS_WAIT;
                    end
                end
            end
            hrcs_pkg::ST_STRAP: begin
                // straps need no load time; attach right away, well inside the deadline
                attach_next = 1'b1; // RQ5
                tmr_stop = 1'b1;
                state_next = hrcs_pkg::ST_ATTACHED;
            end
            hrcs_pkg::ST_EEPROM: begin
                if (eeprom_done) begin
                    tmr_load = 1'b1;
                    tmr_value = cyc(hrcs_pkg::ATTACH_CYC);
                    state_next = hrcs_pkg::ST_APPLY;
                end else if (tmr_expired) begin
                    cfg_to_next = 1'b1; // RQ8
                    state_next = hrcs_pkg::ST_FAULT;
                end
            end
            hrcs_pkg::ST_SMBUS_WAIT: begin
                if (smbus_load_done) begin
                    tmr_load = 1'b1;
                    tmr_value = cyc(hrcs_pkg::ATTACH_CYC); // RQ11
                    state_next = hrcs_pkg::ST_APPLY;
                end else if (tmr_expired) begin
                    // bus-powered host overran its load budget; flagged, still waiting
                    cfg_to_next = 1'b1; // RQ9
                end
            end
            hrcs_pkg::ST_APPLY: begin
                // settings are latched by the loader; attach on the next cycle
                attach_next = 1'b1; // RQ11
                tmr_stop = 1'b1;
                state_next = hrcs_pkg::ST_ATTACHED;
            end
            hrcs_pkg::ST_ATTACHED: begin
                attach_next = 1'b1;
            end
            hrcs_pkg::ST_FAULT: begin
                // eeprom never answered: hold detached until the next hardware reset
                attach_next = 1'b0;
            end
            default: begin
                state_next = hrcs_pkg::ST_IN_RESET;
            end
        endcase
        rd_en_next = (state_next == hrcs_pkg::ST_EEPROM) && oper_next;
        slave_en_next = (strap_next == hrcs_pkg::CFG_SMBUS) && oper_next; // RQ3
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_reg <= hrcs_pkg::ST_IN_RESET;
            strap_reg <= 2'h0;
            strap_taken_reg <= 1'b0;
            oper_reg <= 1'b0;
            attach_reg <= 1'b0;
            cfg_to_reg <= 1'b0;
            rd_en_reg <= 1'b0;
            slave_en_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            strap_reg <= strap_next;
            strap_taken_reg <= strap_taken_next;
            oper_reg <= oper_next;
            attach_reg <= attach_next;
            cfg_to_reg <= cfg_to_next;
            rd_en_reg <= rd_en_next;
            slave_en_reg <= slave_en_next;
        end
    end

    // ==========================================================
    // output release: inactive levels held for a fixed settle count
    always_comb begin
        inact_cnt_next = inact_cnt_reg;
        active_next = active_reg;
        if (strap_taken_reg && !active_reg) begin
            if (inact_cnt_reg == 5'(hrcs_pkg::OUTPUTS_INACTIVE_CYC - 2)) begin
                active_next = 1'b1; // RQ4
            end else begin
                inact_cnt_next = inact_cnt_reg + 5'h01;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            inact_cnt_reg <= 5'h00;
            active_reg <= 1'b0;
        end else begin
            inact_cnt_reg <= inact_cnt_next;
            active_reg <= active_next;
        end
    end

    // ==========================================================
    // upstream usb state and downstream power; bus reset has priority
    always_comb begin
        usb_next = usb_reg;
        pwr_next = pwr_reg;
        flush_next = 1'b0;
        if (usb_bus_reset && attach_reg) begin
            usb_next.address = hrcs_pkg::USB_ADDR_RESET; // RQ12
            usb_next.configured = 1'b0; // RQ12
            usb_next.suspended = 1'b0; // RQ15
            pwr_next = pwr_reg & battery_charge_port_en; // RQ13
            flush_next = 1'b1; // RQ14
        end else if (attach_reg) begin
            if (usb_set_address) begin
                usb_next.address = usb_new_address;
            end
            if (usb_set_config) begin
                usb_next.configured = 1'b1;
            end
            usb_next.suspended = usb_suspend;
            // unconfigured hub powers only charging ports
            pwr_next = usb_reg.configured ? port_power_request : battery_charge_port_en;
        end else begin
            // before attach only charging ports may carry power
            pwr_next = active_reg ? battery_charge_port_en : '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            usb_reg <= '0;
            pwr_reg <= '0;
            flush_reg <= 1'b0;
        end else begin
            usb_reg <= usb_next;
            pwr_reg <= pwr_next;
            flush_reg <= flush_next;
        end
    end

    // ==========================================================
    // control request watchdog; the limit counts from request start
    always_comb begin
        req_busy_next = req_busy_reg;
        req_cnt_next = req_cnt_reg;
        req_to_next = 1'b0;
        if (usb_bus_reset || ctrl_request_done || !attach_reg) begin
            req_busy_next = 1'b0;
        end else if (ctrl_request_start) begin
            req_busy_next = 1'b1;
            req_cnt_next = '0;
        end else if (req_busy_reg) begin
            if (req_cnt_reg == cyc(hrcs_pkg::REQUEST_CYC - 1)) begin
                req_to_next = 1'b1; // RQ7
                req_busy_next = 1'b0;
            end else begin
                req_cnt_next = req_cnt_reg + 24'h000001;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            req_busy_reg <= 1'b0;
            req_cnt_reg <= 24'h000000;
            req_to_reg <= 1'b0;
        end else begin
            req_busy_reg <= req_busy_next;
            req_cnt_reg <= req_cnt_next;
            req_to_reg <= req_to_next;
        end
    end

    // ==========================================================
    // outputs, straight from flip-flops except downstream_reset, tied low
    assign hub_operational = oper_reg;
    assign outputs_active = active_reg;
    assign eeprom_read_en = rd_en_reg;
    assign smbus_slave_en = slave_en_reg;
    assign usb_attach = attach_reg;
    assign usb_address = usb_reg.address;
    assign usb_configured = usb_reg.configured;
    assign usb_suspended = usb_reg.suspended;
    assign downstream_port_power_en = pwr_reg;
    assign tt_flush = flush_reg;
    assign downstream_reset = 1'b0; // RQ16
    assign config_timeout = cfg_to_reg;
    assign request_timeout = req_to_reg;
endmodule

// [test/hrcs_sequencer_props.sv]
// hrcs_sequencer_props: port assertions for the hub start-up and bus reset sequencer
`timescale 1ns/1ps
module hrcs_sequencer_props (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // straps, loaders and upstream events
    input wire logic [1:0] cfg_sel,
    input wire logic self_powered, eeprom_done, smbus_load_done, usb_bus_reset,
    input wire logic ctrl_request_start, ctrl_request_done,
    input wire logic [hrcs_pkg::NUM_PORTS-1:0] battery_charge_port_en,
    // sequencer outputs
    input wire logic hub_operational, outputs_active, eeprom_read_en, smbus_slave_en,
    input wire logic usb_attach, usb_configured, usb_suspended, tt_flush,
    input wire logic [6:0] usb_address,
    input wire logic [hrcs_pkg::NUM_PORTS-1:0] downstream_port_power_en,
    input wire logic downstream_reset, config_timeout, request_timeout
);
    logic [15:0] rel_cnt_reg, rel_cnt_next, req_cnt_reg, req_cnt_next;
    logic [1:0] strap_reg, strap_next;
    logic req_on_reg, req_on_next;
    // ==========================================================
    // helper state: age since release, strap copy, open request age
    always_comb begin
        rel_cnt_next = (rel_cnt_reg == 16'hffff) ? rel_cnt_reg : rel_cnt_reg + 16'h1;
        strap_next = (rel_cnt_reg == 16'h0) ? cfg_sel : strap_reg;
        req_on_next = req_on_reg;
        req_cnt_next = req_on_reg ? req_cnt_reg + 16'h1 : 16'h0;
        if (ctrl_request_start) begin
            req_on_next = 1'b1;
            req_cnt_next = 16'h0;
        end
        if (ctrl_request_done || usb_bus_reset || request_timeout) begin
            req_on_next = 1'b0;
        end
    end
    // registers only; the age saturates so long runs never wrap
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rel_cnt_reg <= 16'h0;
            strap_reg <= 2'h0;
            req_on_reg <= 1'b0;
            req_cnt_reg <= 16'h0;
        end else begin
            rel_cnt_reg <= rel_cnt_next;
            strap_reg <= strap_next;
            req_on_reg <= req_on_next;
            req_cnt_reg <= req_cnt_next;
        end
    end
    // ==========================================================
    // properties
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    property p_oper; rel_cnt_reg == 16'd5000 |-> hub_operational; endproperty
    a_oper: assert property (p_oper) else $error("not operational in time");
    property p_flow; smbus_slave_en == (hub_operational && strap_reg == 2'h2); endproperty
    a_flow: assert property (p_flow) else $error("smbus enable wrong");
    property p_idle; rel_cnt_reg == 16'd20 |-> outputs_active; endproperty
    a_idle: assert property (p_idle) else $error("outputs late");
    property p_strap; $rose(hub_operational) && (strap_reg[0] == strap_reg[1]) |->
        ##[1:3] usb_attach; endproperty
    a_strap: assert property (p_strap) else $error("strap attach late");
    property p_req; request_timeout |-> req_on_reg && req_cnt_reg inside {[49995:50005]};
    endproperty
    a_req: assert property (p_req) else $error("request flag wrong");
    property p_eep; eeprom_read_en && eeprom_done |-> ##[1:3] usb_attach; endproperty
    a_eep: assert property (p_eep) else $error("eeprom attach late");
    property p_self; strap_reg == 2'h2 && self_powered |-> !config_timeout; endproperty
    a_self: assert property (p_self) else $error("self powered limit");
    property p_smb; smbus_slave_en && smbus_load_done |-> ##[1:3] usb_attach; endproperty
    a_smb: assert property (p_smb) else $error("smbus attach late");
    property p_addr; usb_attach && usb_bus_reset |=>
        usb_address == 7'h00 && !usb_configured && !usb_suspended; endproperty
    a_addr: assert property (p_addr) else $error("bus reset state");
    property p_pwr; usb_attach && usb_bus_reset |=> downstream_port_power_en ==
        ($past(downstream_port_power_en) & $past(battery_charge_port_en)); endproperty
    a_pwr: assert property (p_pwr) else $error("bus reset power");
    property p_tt; usb_attach && usb_bus_reset |=> tt_flush; endproperty
    a_tt: assert property (p_tt) else $error("no flush");
    property p_down; usb_bus_reset |=> !downstream_reset [*3]; endproperty
    a_down: assert property (p_down) else $error("reset passed down");
endmodule

bind hrcs_sequencer hrcs_sequencer_props props (.clk_sys, .reset, .cfg_sel, .self_powered,
    .eeprom_done, .smbus_load_done, .usb_bus_reset, .ctrl_request_start, .ctrl_request_done,
    .battery_charge_port_en, .hub_operational, .outputs_active, .eeprom_read_en,
    .smbus_slave_en, .usb_attach, .usb_configured, .usb_suspended, .tt_flush, .usb_address,
    .downstream_port_power_en, .downstream_reset, .config_timeout, .request_timeout);

// [test/hrcs_host_model.sv]
// hrcs_host_model: upstream host and configuration loaders facing the sequencer
`timescale 1ns/1ps
module hrcs_host_model #(
    parameter int HOST_WAIT = 200,
    parameter int LOAD_DELAY = 300
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // sequencer status and bench request
    input wire logic usb_attach, eeprom_read_en, smbus_slave_en, bus_reset_req,
    // loader completion and upstream reset
    output logic eeprom_done, smbus_load_done, usb_bus_reset
);
    int att_cnt;
    int load_cnt;
    // loaders report once as a pulse; delays are scaled but stay inside the load limits
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            att_cnt <= 0;
            load_cnt <= 0;
            eeprom_done <= 1'b0;
            smbus_load_done <= 1'b0;
            usb_bus_reset <= 1'b0;
        end else begin
            att_cnt <= usb_attach ? att_cnt + 1 : 0;
            load_cnt <= ((eeprom_read_en || smbus_slave_en) && !usb_attach) ? load_cnt + 1 : 0;
            eeprom_done <= eeprom_read_en && (load_cnt == LOAD_DELAY);
            smbus_load_done <= smbus_slave_en && !usb_attach && (load_cnt == LOAD_DELAY);
            usb_bus_reset <= bus_reset_req && usb_attach && (att_cnt >= HOST_WAIT);
        end
    end
endmodule

// [test/hrcs_sequencer_bench.sv]
// hrcs_sequencer_bench: start-up flows, upstream bus reset and request watchdog
`timescale 1ns/1ps
module hrcs_sequencer_bench;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [1:0] cfg_sel = 2'h0;
    logic self_powered = 1'b0, usb_suspend = 1'b0, usb_set_address = 1'b0;
    logic usb_set_config = 1'b0, bus_reset_req = 1'b0;
    logic ctrl_request_start = 1'b0, ctrl_request_done = 1'b0;
    logic [6:0] usb_new_address = 7'h00;
    logic [hrcs_pkg::NUM_PORTS-1:0] battery_charge_port_en = 4'h5, port_power_request = 4'h0;
    logic eeprom_done, smbus_load_done, usb_bus_reset, hub_operational, outputs_active;
    logic eeprom_read_en, smbus_slave_en, usb_attach, usb_configured, usb_suspended;
    logic tt_flush, downstream_reset, config_timeout, request_timeout;
    logic [6:0] usb_address;
    logic [hrcs_pkg::NUM_PORTS-1:0] downstream_port_power_en;
    int miscompares = 0;
    int cmp_count = 0;
    int n;

    // ==========================================================
    // clock, design and far side
    always #50 clk_sys = ~clk_sys;
    hrcs_sequencer dut (.clk_sys, .reset, .cfg_sel, .self_powered, .eeprom_done,
        .smbus_load_done, .usb_bus_reset, .usb_suspend, .usb_set_address, .usb_new_address,
        .usb_set_config, .ctrl_request_start, .ctrl_request_done, .battery_charge_port_en,
        .port_power_request, .hub_operational, .outputs_active, .eeprom_read_en,
        .smbus_slave_en, .usb_attach, .usb_address, .usb_configured, .usb_suspended,
        .downstream_port_power_en, .tt_flush, .downstream_reset, .config_timeout,
        .request_timeout);
    hrcs_host_model #(.HOST_WAIT(200), .LOAD_DELAY(300)) host (.clk_sys, .reset, .usb_attach,
        .eeprom_read_en, .smbus_slave_en, .bus_reset_req, .eeprom_done, .smbus_load_done,
        .usb_bus_reset);

    // ==========================================================
    // shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // bounded wait; the count tells how many edges it took
    task automatic wait_for(ref logic sig, input int limit, output int cnt);
        cnt = 0;
        while (sig !== 1'b1 && cnt < limit) begin
            @(posedge clk_sys);
            #1;
            cnt++;
        end
    endtask
    task automatic startup(input logic [1:0] cfg, input logic sp);
        @(posedge clk_sys);
        reset <= 1'b1;
        cfg_sel <= cfg;
        self_powered <= sp;
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        wait_for(hub_operational, 5010, n);
        check(hub_operational, 1'b1);
        check(outputs_active, 1'b1);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // scenarios
    task automatic t_strap(input logic [1:0] cfg);
        startup(cfg, 1'b0);
        wait_for(usb_attach, 4, n);
        check(usb_attach, 1'b1);
        check({eeprom_read_en, smbus_slave_en}, 2'h0);
    endtask
    task automatic t_eeprom;
        startup(2'h1, 1'b0);
        check({eeprom_read_en, usb_attach}, 2'h2);
        wait_for(usb_attach, 400, n);
        check({usb_attach, config_timeout}, 2'h2);
    endtask
    // smbus load in either power mode, left attached for the bus reset that follows
    task automatic t_smbus(input logic sp);
        startup(2'h2, sp);
        check({smbus_slave_en, usb_attach}, 2'h2);
        wait_for(usb_attach, 400, n);
        check({usb_attach, config_timeout}, 2'h2);
    endtask
    // suspend stays high so a lazy clear from the input cannot hide the resume
    task automatic t_bus_reset;
        @(posedge clk_sys);
        usb_new_address <= 7'h2a;
        usb_set_address <= 1'b1;
        usb_set_config <= 1'b1;
        usb_suspend <= 1'b1;
        port_power_request <= 4'hf;
        @(posedge clk_sys);
        usb_set_address <= 1'b0;
        usb_set_config <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        check({usb_address, usb_configured, usb_suspended}, {7'h2a, 2'h3});
        check(downstream_port_power_en, 4'hf);
        @(posedge clk_sys);
        bus_reset_req <= 1'b1;
        wait_for(usb_bus_reset, 300, n);
        @(posedge clk_sys);
        #1;
        check({usb_address, usb_configured}, 8'h00);
        check(usb_suspended, 1'b0);
        check(downstream_port_power_en, battery_charge_port_en);
        check(tt_flush, 1'b1);
        check(downstream_reset, 1'b0);
        @(posedge clk_sys);
        bus_reset_req <= 1'b0;
        usb_suspend <= 1'b0;
    endtask
    // a finished request must not leak into the timing of the next one
    task automatic t_request;
        repeat (4) @(posedge clk_sys);
        ctrl_request_start <= 1'b1;
        @(posedge clk_sys);
        ctrl_request_start <= 1'b0;
        repeat (100) @(posedge clk_sys);
        ctrl_request_done <= 1'b1;
        @(posedge clk_sys);
        ctrl_request_done <= 1'b0;
        ctrl_request_start <= 1'b1;
        @(posedge clk_sys);
        ctrl_request_start <= 1'b0;
        wait_for(request_timeout, 50100, n);
        check(request_timeout, 1'b1);
        check(n >= 49990 && n <= 50010, 1'b1);
    endtask

    // ==========================================================
    // main sequence and watchdog
    initial begin
        t_strap(2'h0);
        t_strap(2'h3);
        t_eeprom;
        t_smbus(1'b0);
        t_smbus(1'b1);
        t_bus_reset;
        t_request;
        tally_and_finish;
    end
    initial begin
        #10000000;
        miscompares++;
        tally_and_finish;
    end
endmodule
